// File: tpg_pkg.sv
/*
 * Constants for the CSI-2 test pattern generator: register map, field
 * positions, values after reset, bar colours and timing.
 * Assumes a 250 MHz clock and an AXI4-Lite slave with 32-bit data.
 */
// Behaviour
// - Two pattern kinds, colour bars and fixed colour.
// - Eight bars AA 33 F0 7F 55 CC 0F 80.
// - Last bar stretches to fill the line.
// - Bar count selectable as 1, 2, 4, 8.
// - Programmable line length sets packet payload.
// - Programmable bar length in bytes.
// - Long packets carry programmable datatype and channel.
// - Exactly the programmed active lines per frame.
// - Frame spans the programmed total line periods.
// - Line period programmable in 10 ns steps.
// - Front porch blank lines before frame end.
// - Back porch blank lines after frame start.
// - Builds CSI-2 packets for the transmitter directly.
// - Fixed colour uses the same dimensions.
// - Fixed colour alternates data and inverse per bar.
// - Block length up to 16, repeats.
// - Sixteen byte registers hold the block.
package tpg_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_CTL = 8'h00;
    localparam logic [7:0] A_CFG = 8'h04;
    localparam logic [7:0] A_CSI_DI = 8'h08;
    localparam logic [7:0] A_LINE_SIZE = 8'h0c;
    localparam logic [7:0] A_BAR_SIZE = 8'h10;
    localparam logic [7:0] A_ACT_LPF = 8'h14;
    localparam logic [7:0] A_TOT_LPF = 8'h18;
    localparam logic [7:0] A_LINE_PD = 8'h1c;
    localparam logic [7:0] A_VBP = 8'h20;
    localparam logic [7:0] A_VFP = 8'h24;
    localparam logic [7:0] A_STAT = 8'h28;
    localparam logic [7:0] A_LINE_IDX = 8'h2c;
    localparam logic [7:0] A_BLK_BASE = 8'h40;
    localparam logic [7:0] A_BLK_LAST = 8'h7c;
    // Field positions.
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_MODE_BIT = 1;
    localparam int CFG_BARS_LSB = 0;
    localparam int CFG_BLK_LSB = 8;
    localparam int DI_VC_LSB = 6;
    // Values after reset.
    localparam logic [1:0] RST_BARS = 2'h3;
    localparam logic [4:0] RST_BLK_LEN = 5'h03;
    localparam logic [15:0] RST_LINE_SIZE = 16'h0010;
    localparam logic [15:0] RST_BAR_SIZE = 16'h0002;
    localparam logic [15:0] RST_ACT_LPF = 16'h0004;
    localparam logic [15:0] RST_TOT_LPF = 16'h0008;
    localparam logic [15:0] RST_LINE_PD = 16'h0010;
    localparam logic [7:0] RST_VBP = 8'h01;
    localparam logic [7:0] RST_VFP = 8'h01;
    // CSI-2 short packet datatypes.
    localparam logic [5:0] DT_FS = 6'h00;
    localparam logic [5:0] DT_FE = 6'h01;
    // Line period unit and clock period, both in ns.
    localparam int PD_UNIT_NS = 10;
    localparam int CLK_NS = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] BAR_VAL [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f,
                                          8'h55, 8'hcc, 8'h0f, 8'h80};
    typedef enum logic [1:0] {K_FS, K_ACT, K_FE} tpg_kind_e;
    typedef enum logic [1:0] {G_IDLE, G_WAIT, G_HDR, G_DATA} tpg_gen_e;
endpackage

// File: tpg_rst_sync.sv
/*
 * Reset synchroniser: asserts at once, releases after two clock edges.
 * Assumes the raw reset is active low.
 */
`timescale 1ns/1ns
module tpg_rst_sync (
    input wire logic clk, // Clock.
    input wire logic rst_in_n, // Raw reset, active low.
    output logic rst_out_n // Synchronised reset, active low.
);
    logic meta_r;

    always_ff @(posedge clk or negedge rst_in_n) begin
        if (!rst_in_n) begin
            meta_r <= 1'b0;
            rst_out_n <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            rst_out_n <= meta_r;
        end
    end
endmodule

// File: tpg_pat_byte.sv
/*
 * Pattern byte selector for one data byte of an active line.
 * Assumes the bar index never exceeds the programmed bar count.
 */
`timescale 1ns/1ns
module tpg_pat_byte (
    input wire logic fixed_mode, // High for fixed colour, low for bars.
    input wire logic [2:0] bar_idx, // Current bar within the line.
    input wire logic [7:0] blk_byte, // Block byte at the current position.
    output logic [7:0] pat // Byte to send.
);
    import tpg_pkg::*;

    always_comb begin
        if (fixed_mode) begin
            pat = blk_byte ^ {8{bar_idx[0]}};
        end else begin
            pat = BAR_VAL[bar_idx];
        end
    end
endmodule

// File: tpg_top.sv
/*
 * CSI-2 test pattern generator with an AXI4-Lite register slave.
 * Emits packet beats to the CSI-2 transmitter: one header beat per
 * packet, then payload bytes for long packets. The transmitter adds ECC
 * and CRC and may stall with TX_READY low.
 */
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module tpg_top (
    input wire logic MCLK, // 250 MHz clock.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire logic [tpg_pkg::ADDR_W-1:0] S_AXI_AWADDR, // Write address.
    input wire logic S_AXI_AWVALID, // Write address valid.
    output logic S_AXI_AWREADY, // Write address ready.
    input wire logic [31:0] S_AXI_WDATA, // Write data.
    input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
    input wire logic S_AXI_WVALID, // Write data valid.
    output logic S_AXI_WREADY, // Write data ready.
    output logic [1:0] S_AXI_BRESP, // Write response.
    output logic S_AXI_BVALID, // Write response valid.
    input wire logic S_AXI_BREADY, // Write response ready.
    input wire logic [tpg_pkg::ADDR_W-1:0] S_AXI_ARADDR, // Read address.
    input wire logic S_AXI_ARVALID, // Read address valid.
    output logic S_AXI_ARREADY, // Read address ready.
    output logic [31:0] S_AXI_RDATA, // Read data.
    output logic [1:0] S_AXI_RRESP, // Read response.
    output logic S_AXI_RVALID, // Read data valid.
    input wire logic S_AXI_RREADY, // Read data ready.
    input wire logic TX_READY, // Transmitter takes a beat.
    output logic TX_VALID, // Beat valid.
    output logic TX_HDR, // Beat is a packet header.
    output logic TX_LAST, // Last beat of a packet.
    output logic [7:0] TX_DI, // Channel and datatype of the header.
    output logic [15:0] TX_WC, // Word count or frame number.
    output logic [7:0] TX_DATA // Payload byte.
);
    import tpg_pkg::*;

    logic rst_n;
    tpg_rst_sync u_rst (.clk(MCLK), .rst_in_n(RST_N), .rst_out_n(rst_n));

    // Register file.
    logic en_r, en_nxt, mode_r, mode_nxt;
    logic [1:0] bars_r, bars_nxt;
    logic [4:0] blk_len_r, blk_len_nxt;
    logic [7:0] di_r, di_nxt, vbp_r, vbp_nxt, vfp_r, vfp_nxt;
    logic [15:0] lsize_r, lsize_nxt, bsize_r, bsize_nxt;
    logic [15:0] act_r, act_nxt, tot_r, tot_nxt, pd_r, pd_nxt;
    logic [7:0] blk_r [16];
    logic [7:0] blk_nxt [16];
    // Bus handshake state.
    logic awrdy_r, awrdy_nxt, bvld_r, bvld_nxt, arrdy_r, arrdy_nxt;
    logic rvld_r, rvld_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // Generator state.
    tpg_gen_e st_r, st_nxt;
    tpg_kind_e kind_r, kind_nxt;
    logic pend_r, pend_nxt, stop_r, stop_nxt;
    logic [3:0] acc_r, acc_nxt, pos_r, pos_nxt;
    logic [15:0] line_r, line_nxt, pdc_r, pdc_nxt, bcnt_r, bcnt_nxt;
    logic [15:0] barc_r, barc_nxt, frm_r, frm_nxt;
    logic [2:0] bar_r, bar_nxt;
    logic ov_r, ov_nxt, oh_r, oh_nxt, ol_r, ol_nxt;
    logic [7:0] odi_r, odi_nxt, od_r, od_nxt;
    logic [15:0] owc_r, owc_nxt;

    logic wr_go, rd_go, adv, unit_tick, line_tick;
    logic [3:0] acc_sum;
    logic [2:0] bar_last;
    logic [15:0] act_first, act_end, fe_line;
    logic [7:0] pat;

    function automatic logic hit(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= A_LINE_IDX ||
               (a >= A_BLK_BASE && a <= A_BLK_LAST));
    endfunction

    function automatic logic [31:0] regval(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        if (a >= A_BLK_BASE) begin
            v[7:0] = blk_r[a[5:2]];
        end else begin
            case (a)
                A_CTL: v = {30'h0, mode_r, en_r};
                A_CFG: v = {19'h0, blk_len_r, 6'h0, bars_r};
                A_CSI_DI: v = {24'h0, di_r};
                A_LINE_SIZE: v = {16'h0, lsize_r};
                A_BAR_SIZE: v = {16'h0, bsize_r};
                A_ACT_LPF: v = {16'h0, act_r};
                A_TOT_LPF: v = {16'h0, tot_r};
                A_LINE_PD: v = {16'h0, pd_r};
                A_VBP: v = {24'h0, vbp_r};
                A_VFP: v = {24'h0, vfp_r};
                A_STAT: v = {frm_r, 15'h0, st_r != G_IDLE};
                A_LINE_IDX: v = {16'h0, line_r};
                default: v = 32'h0;
            endcase
        end
        return v;
    endfunction

    // The slave takes address and data in the same cycle, so both must
    // be offered; one cycle of ready, then the response.
    assign wr_go = awrdy_r && S_AXI_AWVALID && S_AXI_WVALID;
    assign rd_go = arrdy_r && S_AXI_ARVALID;

    always_comb begin
        awrdy_nxt = !awrdy_r && !bvld_r && S_AXI_AWVALID && S_AXI_WVALID;
        bvld_nxt = bvld_r && !S_AXI_BREADY;
        bresp_nxt = bresp_r;
        arrdy_nxt = !arrdy_r && !rvld_r && S_AXI_ARVALID;
        rvld_nxt = rvld_r && !S_AXI_RREADY;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (wr_go) begin
            bvld_nxt = 1'b1;
            bresp_nxt = hit(S_AXI_AWADDR) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rd_go) begin
            rvld_nxt = 1'b1;
            rresp_nxt = hit(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            rdata_nxt = hit(S_AXI_ARADDR) ? regval(S_AXI_ARADDR) : 32'h0;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            awrdy_r <= 1'b0;
            bvld_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arrdy_r <= 1'b0;
            rvld_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0;
        end else begin
            awrdy_r <= awrdy_nxt;
            bvld_r <= bvld_nxt;
            bresp_r <= bresp_nxt;
            arrdy_r <= arrdy_nxt;
            rvld_r <= rvld_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    always_comb begin
        logic [31:0] m, w;
        m = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
             {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
        w = (regval(S_AXI_AWADDR) & ~m) | (S_AXI_WDATA & m);
        en_nxt = en_r;
        mode_nxt = mode_r;
        bars_nxt = bars_r;
        blk_len_nxt = blk_len_r;
        di_nxt = di_r;
        lsize_nxt = lsize_r;
        bsize_nxt = bsize_r;
        act_nxt = act_r;
        tot_nxt = tot_r;
        pd_nxt = pd_r;
        vbp_nxt = vbp_r;
        vfp_nxt = vfp_r;
        blk_nxt = blk_r;
        if (wr_go && hit(S_AXI_AWADDR)) begin
            if (S_AXI_AWADDR >= A_BLK_BASE) begin
                blk_nxt[S_AXI_AWADDR[5:2]] = w[7:0];
            end else begin
                case (S_AXI_AWADDR)
                    A_CTL: begin
                        en_nxt = w[CTL_EN_BIT];
                        mode_nxt = w[CTL_MODE_BIT];
                    end
                    A_CFG: begin
                        bars_nxt = w[CFG_BARS_LSB +: 2];
                        blk_len_nxt = w[CFG_BLK_LSB +: 5];
                    end
                    A_CSI_DI: di_nxt = w[7:0];
                    A_LINE_SIZE: lsize_nxt = w[15:0];
                    A_BAR_SIZE: bsize_nxt = w[15:0];
                    A_ACT_LPF: act_nxt = w[15:0];
                    A_TOT_LPF: tot_nxt = w[15:0];
                    A_LINE_PD: pd_nxt = w[15:0];
                    A_VBP: vbp_nxt = w[7:0];
                    A_VFP: vfp_nxt = w[7:0];
                    default: en_nxt = en_r;
                endcase
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 1'b0;
            mode_r <= 1'b0;
            bars_r <= RST_BARS;
            blk_len_r <= RST_BLK_LEN;
            di_r <= 8'h00;
            lsize_r <= RST_LINE_SIZE;
            bsize_r <= RST_BAR_SIZE;
            act_r <= RST_ACT_LPF;
            tot_r <= RST_TOT_LPF;
            pd_r <= RST_LINE_PD;
            vbp_r <= RST_VBP;
            vfp_r <= RST_VFP;
            for (int i = 0; i < 16; i++) begin
                blk_r[i] <= 8'h00;
            end
        end else begin
            en_r <= en_nxt;
            mode_r <= mode_nxt;
            bars_r <= bars_nxt;
            blk_len_r <= blk_len_nxt;
            di_r <= di_nxt;
            lsize_r <= lsize_nxt;
            bsize_r <= bsize_nxt;
            act_r <= act_nxt;
            tot_r <= tot_nxt;
            pd_r <= pd_nxt;
            vbp_r <= vbp_nxt;
            vfp_r <= vfp_nxt;
            blk_r <= blk_nxt;
        end
    end

    // A 10 ns unit is not a whole number of 4 ns cycles, so a phase
    // accumulator spaces the unit ticks 2 or 3 cycles apart.
    assign acc_sum = acc_r + 4'(CLK_NS);
    assign unit_tick = acc_sum >= 4'(PD_UNIT_NS);
    assign line_tick = unit_tick &&
                       ({1'b0, pdc_r} + 17'd1 >= {1'b0, pd_r});
    assign adv = !ov_r || TX_READY;
    assign bar_last = 3'((4'd1 << bars_r) - 4'd1);
    assign act_first = 16'd1 + {8'h00, vbp_r};
    assign act_end = act_first + act_r;
    assign fe_line = act_end + {8'h00, vfp_r};

    tpg_pat_byte u_pat (
        .fixed_mode(mode_r),
        .bar_idx(bar_r),
        .blk_byte(blk_r[pos_r]),
        .pat(pat)
    );

    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        pend_nxt = pend_r;
        stop_nxt = stop_r;
        acc_nxt = unit_tick ? acc_sum - 4'(PD_UNIT_NS) : acc_sum;
        line_nxt = line_r;
        pdc_nxt = pdc_r;
        bcnt_nxt = bcnt_r;
        barc_nxt = barc_r;
        bar_nxt = bar_r;
        pos_nxt = pos_r;
        frm_nxt = frm_r;
        ov_nxt = ov_r && !TX_READY;
        oh_nxt = oh_r;
        ol_nxt = ol_r;
        odi_nxt = odi_r;
        owc_nxt = owc_r;
        od_nxt = od_r;
        case (st_r)
            G_IDLE: begin
                pdc_nxt = 16'h0;
                if (en_r) begin
                    st_nxt = G_WAIT;
                    line_nxt = 16'h0;
                    pend_nxt = 1'b1;
                end
            end
            G_WAIT: begin
                if (stop_r) begin
                    st_nxt = G_IDLE;
                    stop_nxt = 1'b0;
                    pend_nxt = 1'b0;
                end else if (pend_r) begin
                    pend_nxt = 1'b0;
                    if (line_r == 16'h0) begin
                        st_nxt = G_HDR;
                        kind_nxt = K_FS;
                    end else if (line_r >= act_first && line_r < act_end) begin
                        st_nxt = G_HDR;
                        kind_nxt = K_ACT;
                    end else if (line_r == fe_line) begin
                        st_nxt = G_HDR;
                        kind_nxt = K_FE;
                    end
                end
            end
            G_HDR: begin
                if (adv) begin
                    ov_nxt = 1'b1;
                    oh_nxt = 1'b1;
                    ol_nxt = kind_r != K_ACT;
                    od_nxt = 8'h00;
                    odi_nxt = di_r;
                    owc_nxt = lsize_r;
                    if (kind_r != K_ACT) begin
                        odi_nxt[5:0] = (kind_r == K_FS) ? DT_FS : DT_FE;
                        owc_nxt = frm_r;
                    end
                    if (kind_r == K_FE) begin
                        frm_nxt = frm_r + 16'd1;
                    end
                    st_nxt = (kind_r == K_ACT) ? G_DATA : G_WAIT;
                    bcnt_nxt = 16'h0;
                    barc_nxt = 16'h0;
                    bar_nxt = 3'h0;
                    pos_nxt = 4'h0;
                end
            end
            G_DATA: begin
                if (adv) begin
                    ov_nxt = 1'b1;
                    oh_nxt = 1'b0;
                    od_nxt = pat;
                    ol_nxt = {1'b0, bcnt_r} + 17'd1 >= {1'b0, lsize_r};
                    bcnt_nxt = bcnt_r + 16'd1;
                    pos_nxt = ({1'b0, pos_r} + 5'd1 >= blk_len_r) ?
                              4'h0 : pos_r + 4'd1;
                    // The last bar never advances, so it fills the line.
                    if ({1'b0, barc_r} + 17'd1 >= {1'b0, bsize_r} &&
                        bar_r < bar_last) begin
                        bar_nxt = bar_r + 3'd1;
                        barc_nxt = 16'h0;
                    end else begin
                        barc_nxt = barc_r + 16'd1;
                    end
                    if (ol_nxt) begin
                        st_nxt = G_WAIT;
                    end
                end
            end
            default: st_nxt = G_IDLE;
        endcase
        // A line tick sets the pending flag after any clear above; at the end of a frame it loads en_r instead.
        if (st_r != G_IDLE && unit_tick) begin
            pdc_nxt = line_tick ? 16'h0 : pdc_r + 16'd1;
            if (line_tick) begin
                if ({1'b0, line_r} + 17'd1 >= {1'b0, tot_r}) begin
                    line_nxt = 16'h0;
                    stop_nxt = !en_r;
                    pend_nxt = en_r;
                end else begin
                    line_nxt = line_r + 16'd1;
                    pend_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= G_IDLE;
            kind_r <= K_FS;
            pend_r <= 1'b0;
            stop_r <= 1'b0;
            acc_r <= 4'h0;
            line_r <= 16'h0;
            pdc_r <= 16'h0;
            bcnt_r <= 16'h0;
            barc_r <= 16'h0;
            bar_r <= 3'h0;
            pos_r <= 4'h0;
            frm_r <= 16'h0;
            ov_r <= 1'b0;
            oh_r <= 1'b0;
            ol_r <= 1'b0;
            odi_r <= 8'h00;
            owc_r <= 16'h0;
            od_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            pend_r <= pend_nxt;
            stop_r <= stop_nxt;
            acc_r <= acc_nxt;
            line_r <= line_nxt;
            pdc_r <= pdc_nxt;
            bcnt_r <= bcnt_nxt;
            barc_r <= barc_nxt;
            bar_r <= bar_nxt;
            pos_r <= pos_nxt;
            frm_r <= frm_nxt;
            ov_r <= ov_nxt;
            oh_r <= oh_nxt;
            ol_r <= ol_nxt;
            odi_r <= odi_nxt;
            owc_r <= owc_nxt;
            od_r <= od_nxt;
        end
    end

    assign S_AXI_AWREADY = awrdy_r;
    assign S_AXI_WREADY = awrdy_r;
    assign S_AXI_BVALID = bvld_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arrdy_r;
    assign S_AXI_RVALID = rvld_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = rdata_r;
    assign TX_VALID = ov_r;
    assign TX_HDR = oh_r;
    assign TX_LAST = ol_r;
    assign TX_DI = odi_r;
    assign TX_WC = owc_r;
    assign TX_DATA = od_r;

    default clocking @(posedge MCLK); endclocking
    default disable iff (!rst_n);

    sequence seq_long_hdr;
        st_r == G_HDR && kind_r == K_ACT && adv;
    endsequence
    sequence seq_data_beat;
        st_r == G_DATA && adv;
    endsequence

    chk_enable_boundary: assert property (
        st_r == G_WAIT && $past(st_r) == G_IDLE |-> line_r == 16'h0)
        else $error("generator started away from a frame boundary");
    chk_stop_boundary: assert property (
        $rose(stop_r) |-> line_r == 16'h0 && $past(line_tick))
        else $error("generator stop raised mid frame");
    chk_hdr_fields: assert property (
        seq_long_hdr |=> TX_HDR && TX_DI == di_r && TX_WC == lsize_r)
        else $error("long header fields wrong");
    chk_line_restart: assert property (
        seq_long_hdr |=> bar_r == 3'h0 && pos_r == 4'h0 && bcnt_r == 16'h0)
        else $error("line did not restart bar and block");
    chk_last_byte: assert property (
        seq_data_beat |=> TX_LAST == (bcnt_r == lsize_r))
        else $error("payload length does not match line size");
    chk_bar_count: assert property (
        bar_r <= bar_last)
        else $error("bar index beyond programmed count");
    chk_bar_step: assert property (
        seq_data_beat ##0 (barc_r + 16'd1 >= bsize_r && bar_r < bar_last)
        |=> bar_r == $past(bar_r) + 3'd1 && barc_r == 16'h0)
        else $error("bar did not advance after its length");
    chk_frame_span: assert property (
        st_r != G_IDLE && tot_r != 16'h0 |-> line_r < tot_r)
        else $error("line index beyond total lines");
    chk_bar_colour: assert property (
        seq_data_beat ##0 !mode_r |=> TX_DATA == BAR_VAL[$past(bar_r)])
        else $error("bar byte wrong");
    chk_block_wrap: assert property (
        st_r == G_DATA && blk_len_r != 5'h0 |-> {1'b0, pos_r} < blk_len_r)
        else $error("block position beyond block length");
endmodule

// File: tpg_tx_model.sv
/*
 * Behavioural model of the CSI-2 transmitter that takes pattern beats.
 * Assumes one clock shared with the generator; stall makes it slow.
 */
`timescale 1ns/1ns
module tpg_tx_model (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic stall, // High to take a beat every other cycle only.
    output logic tx_ready // Beat accepted.
);
    // Stalling on alternate cycles stresses the hold of each beat.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= stall ? ~tx_ready : 1'b1;
        end
    end
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the pattern generator: registers over
 * AXI4-Lite, colour-bar and fixed-colour frames into a transmitter model.
 */
`timescale 1ns/1ns
module tb_top;
    import tpg_pkg::*;
    logic MCLK = 0, RST_N = 0, stall = 0, awv = 0, wv = 0, br = 0;
    logic arv = 0, rr = 0, awr, wr_rdy, bv, arr, rv, txr, txv, th, tl;
    logic oh, ol;
    logic [7:0] awa = 0, ara = 0, tdi, td, odi, od;
    logic [31:0] wd = 0, rd, rdat;
    logic [1:0] bresp, rresp, ob, orr;
    logic [15:0] twc, owc;
    logic [7:0] blk [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    int fail_count = 0, samples_checked = 0, cyc = 0, bt;
    tpg_top u_dut (.MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .TX_READY(txr), .TX_VALID(txv), .TX_HDR(th),
        .TX_LAST(tl), .TX_DI(tdi), .TX_WC(twc), .TX_DATA(td));
    tpg_tx_model u_tx (.clk(MCLK), .rst_n(RST_N), .stall(stall),
        .tx_ready(txr));
    initial begin
        forever #2 MCLK = ~MCLK;
    end
    // Free edge count, used to time beats against the line period.
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
    end
    task print_verdict;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task stop;
        fail_count++;
        print_verdict;
    endtask
    task chk(input string nm, input logic [31:0] e, s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wait_for(ref logic sig);
        int n;
        n = 0;
        do begin @(posedge MCLK); n++; end while (sig !== 1'b1 && n < 2000);
        if (n >= 2000) stop;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        awa <= a; wd <= v; awv <= 1; wv <= 1;
        wait_for(awr);
        chk("wready", 1, wr_rdy);
        // Ready is raised here so that back-to-back writes never lower
        // and raise it in one time step.
        awv <= 0; wv <= 0; br <= 1;
        wait_for(bv);
        br <= 0; ob = bresp;
    endtask
    task rdr(input logic [7:0] a);
        ara <= a; arv <= 1;
        wait_for(arr);
        arv <= 0; rr <= 1;
        wait_for(rv);
        rr <= 0; rd = rdat; orr = rresp;
    endtask
    task beat;
        int n;
        n = 0;
        do begin @(posedge MCLK); n++; end while (!(txv && txr) && n < 2000);
        if (n >= 2000) stop;
        oh = th; odi = tdi; owc = twc; od = td; ol = tl;
        bt = cyc;
    endtask
    function automatic logic [7:0] pat_exp(input logic fx, input int nb,
            input int bs, input int i);
        int b;
        b = i / bs;
        if (b > nb - 1) b = nb - 1;
        if (fx) return b % 2 ? ~blk[i % 4] : blk[i % 4];
        return BAR_VAL[b];
    endfunction
    // Bar size and block size are whole RAW8 pixels.
    task setup(input logic [31:0] ctl, cfg, bs);
        wr(A_LINE_SIZE, 10); wr(A_BAR_SIZE, bs); wr(A_CFG, cfg);
        wr(A_CSI_DI, 8'h6a); wr(A_ACT_LPF, 2); wr(A_TOT_LPF, 6);
        wr(A_LINE_PD, 12); wr(A_VBP, 1); wr(A_VFP, 1); wr(A_CTL, ctl);
    endtask
    task frame(input logic fx, input int nb, bs, fn);
        int n, h0;
        n = 0;
        h0 = 0;
        do begin beat; n++; end while (!(oh && odi[5:0] === DT_FS) && n < 99);
        if (!(oh && odi[5:0] === DT_FS)) stop;
        chk("fs_last", 1, ol);
        chk("fs_wc", fn, owc);
        for (int j = 0; j < 2; j++) begin
            beat; chk("hdr", 1, oh);
            chk("hdr_di", 8'h6a, odi);
            chk("hdr_wc", 10, owc);
            if (j == 1) begin
                chk("line_pd", 12 * PD_UNIT_NS / CLK_NS, bt - h0);
            end
            h0 = bt;
            for (int i = 0; i < 10; i++) begin
                beat; chk("pix", pat_exp(fx, nb, bs, i), od);
            end
            chk("tail", 1, ol);
        end
        beat; chk("fe_dt", DT_FE, odi[5:0]);
        chk("fe_wc", fn, owc);
    endtask
    task test_regs;
        rdr(A_CFG); chk("cfg_rst", 32'h0303, rd);
        rdr(8'h30); chk("rd_unmap", RESP_SLVERR, orr);
        wr(8'h34, 1); chk("wr_unmap", RESP_SLVERR, ob);
    endtask
    task test_bars;
        stall <= 1;
        setup(1, 32'h0303, 1);
        frame(0, 8, 1, 0);
        stall <= 0;
    endtask
    task test_fixed;
        wr(A_CTL, 0);
        for (int n = 0; n < 99; n++) begin
            rdr(A_STAT);
            if (rd[0] === 1'b0) break;
        end
        chk("idle", 0, rd[0]);
        for (int k = 0; k < 4; k++) wr(A_BLK_BASE + 8'(4 * k), blk[k]);
        setup(3, 32'h0401, 5);
        frame(1, 2, 5, 1);
    endtask
    initial begin
        repeat (10) @(posedge MCLK);
        RST_N <= 1;
        repeat (3) @(posedge MCLK);
        test_regs;
        test_bars;
        test_fixed;
        print_verdict;
    end
endmodule
